// File: bench/host_mem_model.sv
// Host shared memory behind the engine's word port.
// Answers one access at a time, after one or four cycles.
`timescale 1ns/1ps
`default_nettype none
module host_mem_model (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	input  wire logic        i_slow,
	input  wire logic        i_req,
	input  wire logic        i_we,
	input  wire logic [31:0] i_addr,
	input  wire logic [31:0] i_wdata,
	output logic             o_ack,
	output logic      [31:0] o_rdata
);
	logic [31:0] mem [0:4095];
	logic [1:0]  dly;
	initial begin
		for (int i = 0; i < 4096; i++)
			mem[i] = 32'h0;
		o_ack = 1'b0;
		o_rdata = 32'h5A5A_5A5A;
	end
	// Read data only good with ack; scrambled otherwise
	always @(posedge i_core_clk) begin
		o_ack <= 1'b0;
		o_rdata <= ~o_rdata;
		if (i_rst)
			dly <= 2'h0;
		else if (i_req && !o_ack) begin
			if (dly == (i_slow ? 2'h3 : 2'h0)) begin
				o_ack <= 1'b1;
				dly <= 2'h0;
				if (i_we)
					mem[i_addr[13:2]] <= i_wdata;
				else
					o_rdata <= mem[i_addr[13:2]];
			end else
				dly <= dly + 2'h1;
		end
	end
endmodule
`default_nettype wire

// File: bench/result_dest_checker.sv
// Port checker for the result and destination ring engine.
// Assumes the bench keeps descriptors below DESC_TOP and buffers above it.
`timescale 1ns/1ps
`default_nettype none
module result_dest_checker #(
	parameter logic [31:0] DESC_TOP = 32'h0000_1000
) (
	input wire logic        i_core_clk,
	input wire logic        i_rst,
	input wire logic        i_ce,
	input wire logic        i_awvalid,
	input wire logic        o_awready,
	input wire logic        i_wvalid,
	input wire logic        o_wready,
	input wire logic        o_bvalid,
	input wire logic        i_bready,
	input wire logic [1:0]  o_bresp,
	input wire logic        i_arvalid,
	input wire logic        o_arready,
	input wire logic        o_rvalid,
	input wire logic        o_res_ready,
	input wire logic        o_dst_ready,
	input wire logic        o_mem_req,
	input wire logic        o_mem_we,
	input wire logic [31:0] o_mem_addr,
	input wire logic [31:0] o_mem_wdata,
	input wire logic        i_mem_ack,
	input wire logic [31:0] i_mem_rdata
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	logic [31:0] ok0;
	logic [31:0] ok1;
	logic        dwr;
	assign dwr = o_mem_req && o_mem_we && o_mem_addr < DESC_TOP;
	// Two slots, since the rings interleave their fetches
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			ok0 <= 32'hFFFF_FFFF;
			ok1 <= 32'hFFFF_FFFF;
		end else if (i_mem_ack && o_mem_req && !o_mem_we && !o_mem_addr[2] && i_mem_rdata[31]) begin
			ok0 <= o_mem_addr + 32'h0000_0004;
			ok1 <= ok0;
		end
	end
	sequence s_wr_taken;
		o_awready && i_awvalid && o_wready && i_wvalid ##1 i_ce;
	endsequence
	sequence s_ptr_fetch;
		$rose(o_mem_req) && !o_mem_we && o_mem_addr < DESC_TOP && o_mem_addr[2];
	endsequence
	chk_own_gate: assert property (s_ptr_fetch |-> o_mem_addr == ok0 || o_mem_addr == ok1)
		else $error("pointer word fetched without an owned control word");
	chk_own_clear: assert property (dwr |-> !o_mem_wdata[31])
		else $error("descriptor written back still owned");
	chk_word0_only: assert property (dwr |-> !o_mem_addr[2] && !o_mem_wdata[30])
		else $error("pointer word or link bit written");
	chk_rsvd_zero: assert property (dwr |-> o_mem_wdata[24:16] == 9'h000 && !o_mem_wdata[28])
		else $error("reserved descriptor bits written nonzero");
	chk_len_words: assert property (dwr |-> o_mem_wdata[1:0] == 2'h0)
		else $error("returned byte count not whole words");
	chk_req_hold: assert property (o_mem_req && !i_mem_ack |=>
		o_mem_req && $stable(o_mem_addr) && $stable(o_mem_wdata) && $stable(o_mem_we))
		else $error("memory request changed before ack");
	chk_req_drop: assert property (o_mem_req && i_mem_ack && i_ce |=> !o_mem_req)
		else $error("memory request kept after ack");
	chk_wr_resp: assert property (s_wr_taken |=> o_bvalid)
		else $error("write response late");
	chk_rd_resp: assert property (i_arvalid && o_arready |=> o_rvalid)
		else $error("read response late");
	chk_b_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write response dropped early");
	chk_ce_quiet: assert property (!i_ce |-> !(o_awready || o_wready || o_arready
		|| o_res_ready || o_dst_ready))
		else $error("ready high while clock enable low");
endmodule
bind result_dest_descriptor_ring_dma result_dest_checker chk_u (.i_core_clk, .i_rst, .i_ce,
	.i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bvalid, .i_bready, .o_bresp, .i_arvalid,
	.o_arready, .o_rvalid, .o_res_ready, .o_dst_ready, .o_mem_req, .o_mem_we, .o_mem_addr,
	.o_mem_wdata, .i_mem_ack, .i_mem_rdata);
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench: AXI4-Lite host, output streams and host memory model.
// Assumes descriptors below 0x1000 and buffers above.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        i_core_clk, i_rst, i_ce, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
	logic        i_res_valid, i_res_last, i_dst_valid, i_dst_last, mem_slow;
	logic [11:0] i_awaddr, i_araddr;
	logic [31:0] i_wdata, i_res_data, i_dst_data;
	logic [15:0] lfsr;
	logic [33:0] e;
	wire logic   o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
	wire logic   o_mem_req, o_mem_we, i_mem_ack, o_res_ready, o_dst_ready;
	wire logic [1:0]  o_bresp, o_rresp;
	wire logic [31:0] o_rdata, o_mem_addr, o_mem_wdata, i_mem_rdata;
	wire logic [3:0]  i_wstrb = 4'hF;
	wire logic [2:0]  i_awprot = 3'h0;
	wire logic [2:0]  i_arprot = 3'h0;
	int          failures, comparisons;
	logic [33:0] rq [$];
	logic [63:0] wq [$];
	result_dest_descriptor_ring_dma #(.POLL_CYCLES(2)) dut_u (.i_core_clk, .i_rst, .i_ce,
		.i_awvalid, .o_awready, .i_awaddr, .i_awprot, .i_wvalid, .o_wready, .i_wdata, .i_wstrb,
		.o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr, .i_arprot, .o_rvalid,
		.i_rready, .o_rdata, .o_rresp, .o_irq, .o_mem_req, .o_mem_we, .o_mem_addr, .o_mem_wdata,
		.i_mem_ack, .i_mem_rdata, .i_res_valid, .i_res_data, .i_res_last, .o_res_ready,
		.i_dst_valid, .i_dst_data, .i_dst_last, .o_dst_ready);
	host_mem_model mem_u (.i_core_clk, .i_rst, .i_slow(mem_slow), .i_req(o_mem_req),
		.i_we(o_mem_we), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_ack(i_mem_ack),
		.o_rdata(i_mem_rdata));
	always #25 i_core_clk = ~i_core_clk;
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return {lfsr, ~lfsr};
	endfunction
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		if (failures == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge i_core_clk) begin
		if (o_bvalid && i_bready) begin
			e = rq.size() ? rq.pop_front() : 'x;
			chk(o_bresp, e[33:32]);
		end
		if (o_rvalid && i_rready) begin
			e = rq.size() ? rq.pop_front() : 'x;
			chk({o_rresp, o_rdata}, e);
		end
		if (o_mem_req && o_mem_we && i_mem_ack && i_ce)
			chk({o_mem_addr, o_mem_wdata}, wq.size() ? wq.pop_front() : 'x);
	end
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		rq.push_back({r, 32'h0});
		@(posedge i_core_clk);
		i_awvalid <= 1'b1;
		i_awaddr <= a;
		i_wvalid <= 1'b1;
		i_wdata <= d;
		do begin
			@(posedge i_core_clk);
			if (o_awready) i_awvalid <= 1'b0;
			if (o_wready) i_wvalid <= 1'b0;
			if (!i_bready) i_bready <= o_bvalid;
		end while (!(o_bvalid && i_bready));
		i_bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [33:0] x);
		rq.push_back(x);
		@(posedge i_core_clk);
		i_arvalid <= 1'b1;
		i_araddr <= a;
		i_rready <= 1'b1;
		do begin
			@(posedge i_core_clk);
			if (o_arready) i_arvalid <= 1'b0;
		end while (!o_rvalid);
		i_rready <= 1'b0;
	endtask
	task automatic send(input logic dst, input logic [31:0] a, input logic last, input logic keep);
		logic [31:0] d;
		d = rnd();
		if (keep) wq.push_back({a, d});
		@(posedge i_core_clk);
		i_res_valid <= !dst;
		i_dst_valid <= dst;
		i_res_data <= d;
		i_dst_data <= d;
		i_res_last <= last;
		i_dst_last <= last;
		do @(posedge i_core_clk); while (!(dst ? o_dst_ready : o_res_ready));
		i_res_valid <= 1'b0;
		i_dst_valid <= 1'b0;
		i_res_data <= ~d;
		i_dst_data <= ~d;
	endtask
	// Pointer first, control word with owner bit last
	task automatic desc(input logic [31:0] at, input logic [31:0] w0, input logic [31:0] w1);
		@(negedge i_core_clk);
		mem_u.mem[at[13:2] + 12'h001] = w1;
		mem_u.mem[at[13:2]] = w0;
	endtask
	task automatic drain();
		while (wq.size() != 0) @(posedge i_core_clk);
		repeat (4) @(posedge i_core_clk);
	endtask
	initial begin
		repeat (20000) @(posedge i_core_clk);
		failures++;
		test_done();
	end
	initial begin
		{i_core_clk, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, mem_slow} = '0;
		{i_res_valid, i_res_last, i_dst_valid, i_dst_last} = '0;
		{i_awaddr, i_araddr, i_wdata, i_res_data, i_dst_data} = '0;
		i_rst = 1'b1;
		i_ce = 1'b1;
		lfsr = 16'hF6F5;
		repeat (12) @(posedge i_core_clk);
		i_rst <= 1'b0;
		rd(12'h000, 34'h0);
		rd(12'h00C, 34'h0);
		rd(12'h004, 34'h0);
		rd(12'h018, {2'h2, 32'h0});
		wr(12'h018, 32'h1, 2'h2);
		wr(12'h000, 32'hFFFF_FFFC, 2'h0);
		rd(12'h000, {2'h0, 32'h10});
		i_ce <= 1'b0;
		repeat (3) @(posedge i_core_clk);
		i_ce <= 1'b1;
		desc(32'h0, 32'hC000_0000, 32'h40);
		wr(12'h000, 32'h1, 2'h0);
		repeat (30) @(posedge i_core_clk);
		desc(32'h40, 32'h8000_0000, 32'h1000);
		repeat (30) @(posedge i_core_clk);
		desc(32'h40, 32'h8000_0008, 32'h1000);
		send(1'b0, 32'h1000, 1'b0, 1'b1);
		send(1'b0, 32'h1004, 1'b1, 1'b1);
		wq.push_back({32'h40, 32'h2000_0008});
		drain();
		rd(12'h00C, {2'h0, 32'h1});
		wr(12'h010, 32'h1, 2'h0);
		chk(o_irq, 1'b1);
		wr(12'h00C, 32'h1, 2'h0);
		chk(o_irq, 1'b0);
		desc(32'h48, 32'h8200_0004, 32'h1100);
		send(1'b0, 32'h1100, 1'b1, 1'b1);
		wq.push_back({32'h48, 32'h2200_0004});
		drain();
		rd(12'h00C, 34'h0);
		mem_slow <= 1'b1;
		wr(12'h008, 32'h80, 2'h0);
		rd(12'h008, {2'h0, 32'h80});
		desc(32'h80, 32'hA000_0004, 32'h2000);
		wr(12'h000, 32'h13, 2'h0);
		send(1'b1, 32'h2000, 1'b0, 1'b1);
		send(1'b1, 32'h2004, 1'b1, 1'b0);
		wq.push_back({32'h80, 32'h2800_0004});
		drain();
		desc(32'h50, 32'hA000_0004, 32'h1200);
		send(1'b0, 32'h1200, 1'b0, 1'b1);
		send(1'b0, 32'h1204, 1'b1, 1'b0);
		wq.push_back({32'h50, 32'h2C00_0004});
		drain();
		rd(12'h00C, {2'h0, 32'hF});
		chk(o_irq, 1'b1);
		wr(12'h00C, 32'hF, 2'h0);
		rd(12'h00C, 34'h0);
		test_done();
	end
endmodule
`default_nettype wire

// File: src/mem_port_arbiter.sv
// Two-way round-robin arbiter onto the host memory word port.
// Assumes requesters hold request, address and data until acknowledged.
`timescale 1ns/1ps
`default_nettype none

module mem_port_arbiter (
	input  wire logic             i_core_clk,
	input  wire logic             i_rst,
	input  wire logic             i_ce,
	input  wire logic [1:0]       i_req,
	input  wire logic [1:0]       i_we,
	input  wire logic [1:0][31:0] i_addr,
	input  wire logic [1:0][31:0] i_wdata,
	output logic      [1:0]       o_ack,
	output logic                  o_mem_req,
	output logic                  o_mem_we,
	output logic      [31:0]      o_mem_addr,
	output logic      [31:0]      o_mem_wdata,
	input  wire logic             i_mem_ack
);

	logic owner;
	logic last_owner;
	logic pick;

	// Alternate so a polling ring cannot starve a ring that moves data
	assign pick = i_req[~last_owner] ? ~last_owner : last_owner;

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_mem_req   <= 1'b0;
			o_mem_we    <= 1'b0;
			o_mem_addr  <= 32'h0000_0000;
			o_mem_wdata <= 32'h0000_0000;
			owner       <= 1'b0;
			last_owner  <= 1'b1;
		end else if (i_ce) begin
			if (!o_mem_req) begin
				if (i_req[pick]) begin
					o_mem_req   <= 1'b1;
					owner       <= pick;
					o_mem_we    <= i_we[pick];
					o_mem_addr  <= i_addr[pick];
					o_mem_wdata <= i_wdata[pick];
				end
			end else if (i_mem_ack) begin
				o_mem_req  <= 1'b0;
				last_owner <= owner;
			end
		end
	end

	assign o_ack[0] = i_ce & o_mem_req & i_mem_ack & ~owner;
	assign o_ack[1] = i_ce & o_mem_req & i_mem_ack & owner;

endmodule

`default_nettype wire

// File: src/result_dest_descriptor_ring_dma.sv
// Result and destination descriptor ring engine with an AXI4-Lite register slave.
// Assumes host memory is reached through a request/ack word port on the core clock,
// and that output words arrive on two valid/ready streams with a last marker.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Poll own bit 31 until set
// - Clearing own bit is final write
// - Zero length result descriptor keeps polling
// - Link bit 30: follow pointer, no data
// - Final bit 29 by host or device
// - Result overrun sets bit 27
// - Destination overrun marks result bit 26
// - Destination overrun sets bit 27
// - Bit 25 suppresses done interrupt
// - Length field rewritten with bytes written
// - Link, mask and pointer never changed
module result_dest_descriptor_ring_dma #(
	parameter int AXI_AW      = 12,
	parameter int POLL_CYCLES = result_dest_pkg::POLL_CYCLES
) (
	input  wire logic              i_core_clk,
	input  wire logic              i_rst,
	input  wire logic              i_ce,
	input  wire logic              i_awvalid,
	output logic                   o_awready,
	input  wire logic [AXI_AW-1:0] i_awaddr,
	input  wire logic [2:0]        i_awprot,
	input  wire logic              i_wvalid,
	output logic                   o_wready,
	input  wire logic [31:0]       i_wdata,
	input  wire logic [3:0]        i_wstrb,
	output logic                   o_bvalid,
	input  wire logic              i_bready,
	output logic      [1:0]        o_bresp,
	input  wire logic              i_arvalid,
	output logic                   o_arready,
	input  wire logic [AXI_AW-1:0] i_araddr,
	input  wire logic [2:0]        i_arprot,
	output logic                   o_rvalid,
	input  wire logic              i_rready,
	output logic      [31:0]       o_rdata,
	output logic      [1:0]        o_rresp,
	output logic                   o_irq,
	output logic                   o_mem_req,
	output logic                   o_mem_we,
	output logic      [31:0]       o_mem_addr,
	output logic      [31:0]       o_mem_wdata,
	input  wire logic              i_mem_ack,
	input  wire logic [31:0]       i_mem_rdata,
	input  wire logic              i_res_valid,
	input  wire logic [31:0]       i_res_data,
	input  wire logic              i_res_last,
	output logic                   o_res_ready,
	input  wire logic              i_dst_valid,
	input  wire logic [31:0]       i_dst_data,
	input  wire logic              i_dst_last,
	output logic                   o_dst_ready
);

	// Register bus state
	logic                              aw_hold;
	logic                              w_hold;
	logic [AXI_AW-1:0]                 aw_addr;
	logic [31:0]                       w_data;
	logic [3:0]                        w_strb;
	logic [31:0]                       bmask;
	logic [11:0]                       wr_off;
	logic [11:0]                       rd_off;
	logic                              do_write;
	logic                              wr_hit;
	logic                              rd_hit;
	logic [31:0]                       rd_mux;
	logic [31:0]                       ctrl;
	logic [result_dest_pkg::STAT_W-1:0] status;
	logic [result_dest_pkg::STAT_W-1:0] int_mask;
	logic [result_dest_pkg::STAT_W-1:0] stat_set;
	logic [result_dest_pkg::STAT_W-1:0] stat_clr;
	logic                              dst_over_pend;

	// Per-ring wires
	wire [1:0]       base_wr;
	wire [1:0]       ring_en;
	wire [1:0]       ring_req;
	wire [1:0]       ring_we;
	wire [1:0][31:0] ring_addr;
	wire [1:0][31:0] ring_wdata;
	wire [1:0]       ring_ack;
	wire [1:0][31:0] ring_ptr;
	wire [1:0][2:0]  ring_state;
	wire [1:0]       done_ev;
	wire [1:0]       over_ev;
	wire [1:0]       str_valid;
	wire [1:0][31:0] str_data;
	wire [1:0]       str_last;
	wire [1:0]       str_ready;
	wire             host_final;

	assign str_valid   = {i_dst_valid, i_res_valid};
	assign str_data    = {i_dst_data, i_res_data};
	assign str_last    = {i_dst_last, i_res_last};
	assign o_res_ready = str_ready[result_dest_pkg::RING_RES];
	assign o_dst_ready = str_ready[result_dest_pkg::RING_DST];
	assign ring_en     = {ctrl[result_dest_pkg::CTRL_DST_EN], ctrl[result_dest_pkg::CTRL_RES_EN]};
	assign host_final  = ctrl[result_dest_pkg::CTRL_HOST_FINAL];

	// ---------------- AXI4-Lite write channel ----------------
	assign o_awready = i_ce & ~aw_hold & ~o_bvalid;
	assign o_wready  = i_ce & ~w_hold & ~o_bvalid;
	assign do_write  = aw_hold & w_hold & ~o_bvalid;
	assign wr_off    = {aw_addr[11:2], 2'b00};

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			aw_hold <= 1'b0;
			aw_addr <= '0;
		end else if (i_ce) begin
			if (i_awvalid && o_awready) begin
				aw_hold <= 1'b1;
				aw_addr <= i_awaddr;
			end else if (do_write) begin
				aw_hold <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			w_hold <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (i_ce) begin
			if (i_wvalid && o_wready) begin
				w_hold <= 1'b1;
				w_data <= i_wdata;
				w_strb <= i_wstrb;
			end else if (do_write) begin
				w_hold <= 1'b0;
			end
		end
	end

	always_comb begin
		for (int b = 0; b < 4; b++) begin
			bmask[8*b +: 8] = {8{w_strb[b]}};
		end
	end

	assign wr_hit = (wr_off == result_dest_pkg::OFF_CTRL) ||
			(wr_off == result_dest_pkg::OFF_RES_BASE) ||
			(wr_off == result_dest_pkg::OFF_DST_BASE) ||
			(wr_off == result_dest_pkg::OFF_STATUS) ||
			(wr_off == result_dest_pkg::OFF_MASK) ||
			(wr_off == result_dest_pkg::OFF_STATE);

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_bvalid <= 1'b0;
			o_bresp  <= result_dest_pkg::RESP_OKAY;
		end else if (i_ce) begin
			if (do_write) begin
				o_bvalid <= 1'b1;
				o_bresp  <= wr_hit ? result_dest_pkg::RESP_OKAY : result_dest_pkg::RESP_SLVERR;
			end else if (i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			ctrl <= result_dest_pkg::CTRL_RST;
		end else if (i_ce && do_write && wr_off == result_dest_pkg::OFF_CTRL) begin
			ctrl <= ((ctrl & ~bmask) | (w_data & bmask)) & result_dest_pkg::CTRL_WMASK;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			int_mask <= result_dest_pkg::MASK_RST;
		end else if (i_ce && do_write && wr_off == result_dest_pkg::OFF_MASK && w_strb[0]) begin
			int_mask <= w_data[result_dest_pkg::STAT_W-1:0];
		end
	end

	// Base pointer loads; an engine that is walking its ring ignores them
	assign base_wr[0] = do_write & (wr_off == result_dest_pkg::OFF_RES_BASE);
	assign base_wr[1] = do_write & (wr_off == result_dest_pkg::OFF_DST_BASE);

	// ---------------- Status, mask and interrupt ----------------
	assign stat_set = {over_ev[1], over_ev[0], done_ev[1], done_ev[0]};
	assign stat_clr = (do_write && wr_off == result_dest_pkg::OFF_STATUS && w_strb[0]) ?
			w_data[result_dest_pkg::STAT_W-1:0] : '0;

	// Set beats a simultaneous write-one-to-clear
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			status <= result_dest_pkg::STATUS_RST;
		end else if (i_ce) begin
			status <= (status & ~stat_clr) | stat_set;
		end
	end

	assign o_irq = |(status & int_mask);

	// Destination overrun waiting to be reported in the next result descriptor
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			dst_over_pend <= 1'b0;
		end else if (i_ce) begin
			if (over_ev[result_dest_pkg::RING_DST]) begin
				dst_over_pend <= 1'b1;
			end else if (done_ev[result_dest_pkg::RING_RES] ||
					(ring_state[result_dest_pkg::RING_RES] == result_dest_pkg::ST_WB &&
					ring_ack[result_dest_pkg::RING_RES])) begin
				dst_over_pend <= 1'b0;
			end
		end
	end

	// ---------------- AXI4-Lite read channel ----------------
	assign o_arready = i_ce & ~o_rvalid;
	assign rd_off    = {i_araddr[11:2], 2'b00};

	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		case (rd_off)
			result_dest_pkg::OFF_CTRL:     rd_mux = ctrl;
			result_dest_pkg::OFF_RES_BASE: rd_mux = ring_ptr[0];
			result_dest_pkg::OFF_DST_BASE: rd_mux = ring_ptr[1];
			result_dest_pkg::OFF_STATUS:   rd_mux[result_dest_pkg::STAT_W-1:0] = status;
			result_dest_pkg::OFF_MASK:     rd_mux[result_dest_pkg::STAT_W-1:0] = int_mask;
			result_dest_pkg::OFF_STATE:    rd_mux[6:0] = {dst_over_pend, ring_state[1], ring_state[0]};
			default:                       rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_rvalid <= 1'b0;
			o_rdata  <= 32'h0000_0000;
			o_rresp  <= result_dest_pkg::RESP_OKAY;
		end else if (i_ce) begin
			if (i_arvalid && o_arready) begin
				o_rvalid <= 1'b1;
				o_rdata  <= rd_mux;
				o_rresp  <= rd_hit ? result_dest_pkg::RESP_OKAY : result_dest_pkg::RESP_SLVERR;
			end else if (i_rready) begin
				o_rvalid <= 1'b0;
			end
		end
	end

	// ---------------- Ring engines ----------------
	for (genvar r = 0; r < result_dest_pkg::NRING; r++) begin : g_ring
		result_dest_pkg::ring_state_t state;
		logic [31:0] ptr;
		logic [31:0] ctl;
		logic [31:0] buf_addr;
		logic [15:0] cnt;
		logic [31:0] word;
		logic        eos;
		logic        ovf;
		logic [15:0] poll_cnt;
		logic [16:0] next_cnt;
		logic        full;
		logic [31:0] wb_word;
		logic [31:0] req_addr;

		assign next_cnt = {1'b0, cnt} + result_dest_pkg::WORD_BYTES;
		assign full     = next_cnt >= {1'b0, ctl[result_dest_pkg::LEN_W-1:0]};

		// Written back: only control and length, ownership cleared last
		always_comb begin
			wb_word = 32'h0000_0000;
			wb_word[result_dest_pkg::LEN_W-1:0] = cnt;
			wb_word[result_dest_pkg::BIT_FINAL] = host_final ?
					ctl[result_dest_pkg::BIT_FINAL] : eos;
			wb_word[result_dest_pkg::BIT_OVER]   = ovf;
			wb_word[result_dest_pkg::BIT_DOVER]  = (r == result_dest_pkg::RING_RES) &&
					dst_over_pend;
			wb_word[result_dest_pkg::BIT_NODONE] = ctl[result_dest_pkg::BIT_NODONE];
			wb_word[result_dest_pkg::BIT_OWN]    = 1'b0;
		end

		always_comb begin
			case (state)
				result_dest_pkg::ST_PTR: req_addr = ptr + result_dest_pkg::PTR_OFS;
				result_dest_pkg::ST_WR:  req_addr = buf_addr + {16'h0000, cnt};
				default:                 req_addr = ptr;
			endcase
		end

		assign ring_req[r]   = (state == result_dest_pkg::ST_CTL) || (state == result_dest_pkg::ST_PTR) ||
				(state == result_dest_pkg::ST_WR) || (state == result_dest_pkg::ST_WB);
		assign ring_we[r]    = (state == result_dest_pkg::ST_WR) || (state == result_dest_pkg::ST_WB);
		assign ring_addr[r]  = req_addr;
		assign ring_wdata[r] = (state == result_dest_pkg::ST_WB) ? wb_word : word;
		assign ring_ptr[r]   = ptr;
		assign ring_state[r] = state;
		assign str_ready[r]  = i_ce && ((state == result_dest_pkg::ST_DATA) ||
				(state == result_dest_pkg::ST_DROP));
		assign done_ev[r]    = (state == result_dest_pkg::ST_WB) && ring_ack[r] &&
				!ctl[result_dest_pkg::BIT_NODONE];
		assign over_ev[r]    = (state == result_dest_pkg::ST_WB) && ring_ack[r] && ovf;

		always_ff @(posedge i_core_clk) begin
			if (i_rst) begin
				state    <= result_dest_pkg::ST_IDLE;
				ptr      <= 32'h0000_0000;
				ctl      <= 32'h0000_0000;
				buf_addr <= 32'h0000_0000;
				cnt      <= 16'h0000;
				word     <= 32'h0000_0000;
				eos      <= 1'b0;
				ovf      <= 1'b0;
				poll_cnt <= 16'h0000;
			end else if (i_ce) begin
				case (state)
					result_dest_pkg::ST_IDLE: begin
						if (base_wr[r]) begin
							ptr <= w_data;
						end else if (ring_en[r]) begin
							state <= result_dest_pkg::ST_CTL;
						end
					end
					result_dest_pkg::ST_CTL: begin
						if (ring_ack[r]) begin
							ctl <= i_mem_rdata;
							if (i_mem_rdata[result_dest_pkg::BIT_OWN]) begin
								state <= result_dest_pkg::ST_PTR;
							end else begin
								state <= result_dest_pkg::ST_WAIT;
							end
						end
					end
					result_dest_pkg::ST_PTR: begin
						if (ring_ack[r]) begin
							if (ctl[result_dest_pkg::BIT_LINK]) begin
								ptr   <= i_mem_rdata;
								state <= result_dest_pkg::ST_CTL;
							end else if (ctl[result_dest_pkg::LEN_W-1:0] == 16'h0000) begin
								state <= result_dest_pkg::ST_WAIT;
							end else begin
								buf_addr <= i_mem_rdata;
								cnt      <= 16'h0000;
								eos      <= 1'b0;
								ovf      <= 1'b0;
								state    <= result_dest_pkg::ST_DATA;
							end
						end
					end
					result_dest_pkg::ST_WAIT: begin
						// Spaced re-reads keep a stalled ring off the host bus
						if (poll_cnt == 16'(POLL_CYCLES - 1)) begin
							poll_cnt <= 16'h0000;
							state    <= ring_en[r] ? result_dest_pkg::ST_CTL :
									result_dest_pkg::ST_IDLE;
						end else begin
							poll_cnt <= poll_cnt + 16'h0001;
						end
					end
					result_dest_pkg::ST_DATA: begin
						if (str_valid[r]) begin
							word  <= str_data[r];
							eos   <= str_last[r];
							state <= result_dest_pkg::ST_WR;
						end
					end
					result_dest_pkg::ST_WR: begin
						if (ring_ack[r]) begin
							cnt <= next_cnt[15:0];
							if (eos) begin
								state <= result_dest_pkg::ST_WB;
							end else if (full) begin
								if (host_final && ctl[result_dest_pkg::BIT_FINAL]) begin
									ovf   <= 1'b1;
									state <= result_dest_pkg::ST_DROP;
								end else begin
									state <= result_dest_pkg::ST_WB;
								end
							end else begin
								state <= result_dest_pkg::ST_DATA;
							end
						end
					end
					result_dest_pkg::ST_DROP: begin
						// Excess words are consumed and lost until the stream ends
						if (str_valid[r] && str_last[r]) begin
							eos   <= 1'b1;
							state <= result_dest_pkg::ST_WB;
						end
					end
					result_dest_pkg::ST_WB: begin
						if (ring_ack[r]) begin
							ptr   <= ptr + result_dest_pkg::DESC_BYTES;
							state <= ring_en[r] ? result_dest_pkg::ST_CTL :
									result_dest_pkg::ST_IDLE;
						end
					end
					default: begin
						state <= result_dest_pkg::ST_IDLE;
					end
				endcase
			end
		end
	end

	mem_port_arbiter u_arb (
		.i_core_clk  (i_core_clk),
		.i_rst       (i_rst),
		.i_ce        (i_ce),
		.i_req       (ring_req),
		.i_we        (ring_we),
		.i_addr      (ring_addr),
		.i_wdata     (ring_wdata),
		.o_ack       (ring_ack),
		.o_mem_req   (o_mem_req),
		.o_mem_we    (o_mem_we),
		.o_mem_addr  (o_mem_addr),
		.o_mem_wdata (o_mem_wdata),
		.i_mem_ack   (i_mem_ack)
	);

endmodule

`default_nettype wire

// File: src/result_dest_pkg.sv
// Shared constants for the result and destination descriptor ring engine.
// Assumes a single core clock; descriptors live in host memory reached by a word port.
`default_nettype none

package result_dest_pkg;

	localparam int NRING    = 2;
	localparam int RING_RES = 0;
	localparam int RING_DST = 1;

	// Descriptor word 0 layout
	localparam int BIT_OWN    = 31;
	localparam int BIT_LINK   = 30;
	localparam int BIT_FINAL  = 29;
	localparam int BIT_OVER   = 27;
	localparam int BIT_DOVER  = 26;
	localparam int BIT_NODONE = 25;
	localparam int LEN_W      = 16;

	localparam logic [31:0] DESC_BYTES = 32'h0000_0008;
	localparam logic [31:0] PTR_OFS    = 32'h0000_0004;
	localparam logic [16:0] WORD_BYTES = 17'h0_0004;

	// Register byte offsets
	localparam logic [11:0] OFF_CTRL     = 12'h000;
	localparam logic [11:0] OFF_RES_BASE = 12'h004;
	localparam logic [11:0] OFF_DST_BASE = 12'h008;
	localparam logic [11:0] OFF_STATUS   = 12'h00C;
	localparam logic [11:0] OFF_MASK     = 12'h010;
	localparam logic [11:0] OFF_STATE    = 12'h014;

	// Control register fields
	localparam int CTRL_RES_EN     = 0;
	localparam int CTRL_DST_EN     = 1;
	localparam int CTRL_HOST_FINAL = 4;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_0013;
	localparam logic [31:0] CTRL_RST   = 32'h0000_0000;

	// Status and mask fields
	localparam int STAT_W        = 4;
	localparam int ST_DONE_RES   = 0;
	localparam int ST_DONE_DST   = 1;
	localparam int ST_OVER_RES   = 2;
	localparam int ST_OVER_DST   = 3;
	localparam logic [STAT_W-1:0] STATUS_RST = 4'h0;
	localparam logic [STAT_W-1:0] MASK_RST   = 4'h0;

	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int POLL_NS       = 1000;
	localparam int POLL_CYCLES   = (POLL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CTL  = 3'b001,
		ST_PTR  = 3'b010,
		ST_WAIT = 3'b011,
		ST_DATA = 3'b100,
		ST_WR   = 3'b101,
		ST_DROP = 3'b110,
		ST_WB   = 3'b111
	} ring_state_t;

endpackage

`default_nettype wire
